// File: src/ddm_lat_cnt.sv
// Down-counter of link clocks that pulses once a latency has run out
`timescale 1ns/1ps
module ddm_lat_cnt
	import ddm_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Control
	input  wire logic             tick,
	input  wire logic             start,
	input  wire logic [LAT_W-1:0] len,
	// Status
	output logic                  busy,
	output logic                  done,
	output logic      [LAT_W-1:0] cnt
);
	wire [LAT_W-1:0] load_len = (len == '0) ? LAT_W'(1) : len;
	wire             last     = tick && (cnt == LAT_W'(1));

	// A new start restarts the count: one operation in flight at a time
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt  <= '0;
			done <= 1'b0;
		end
		else
		begin
			done <= last && !start;
			if (start)
				cnt <= load_len;
			else if (tick && cnt != '0)
				cnt <= cnt - LAT_W'(1);
		end
	end

	assign busy = (cnt != '0);
endmodule

// File: src/ddm_mode_regs.sv
// Mode registers zero and one with latency timing and Avalon-MM access
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module ddm_mode_regs
	import ddm_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Command pins from the controller
	input  wire logic             ck,
	input  wire ddm_cmd_t         cmd_pins,
	// Avalon-MM slave
	input  wire logic [2:0]       address,
	input  wire logic             read,
	input  wire logic             write,
	input  wire logic [3:0]       byteenable,
	input  wire logic [31:0]      writedata,
	output logic      [31:0]      readdata,
	output logic                  waitrequest,
	// Timing events
	output logic                  rd_data_start,
	output logic                  wr_internal,
	output logic                  ap_start,
	output logic                  dll_reset_pulse,
	// Mode outputs
	output logic                  dll_run,
	output logic                  outputs_off,
	output logic      [1:0]       drive_imp,
	output logic      [2:0]       rtt_nom_code,
	output logic                  rtt_wr_on,
	output logic                  wr_dll_needed,
	output logic      [LAT_W-1:0] read_latency
);
	ddm_cmd_t         cmd;
	logic             ck_s;
	logic             ck_d;
	logic [ADR_W-1:0] mode_register_zero;
	logic [ADR_W-1:0] mode_register_one;
	logic [15:0]      cfg;
	logic             ack;
	ddm_state_t       state;
	ddm_state_t       next_state;
	logic             rd_busy;
	logic             wr_busy;
	logic             ap_busy;
	logic             wr_done;
	logic             ap_pend;
	logic [LAT_W-1:0] rd_cnt;
	logic [LAT_W-1:0] wr_cnt;
	logic [LAT_W-1:0] ap_cnt;

	// Pins pass two flops; ck is only sampled, never used as a clock
	ddm_sync #(.W(CMD_W + 1)) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  ({ck, cmd_pins}),
		.dout ({ck_s, cmd})
	);

	always_ff @(posedge clk)
	begin
		if (rst)
			ck_d <= 1'b0;
		else
			ck_d <= ck_s;
	end

	// Command decode on each rising link clock
	wire tick    = ck_s && !ck_d;
	wire sel     = tick && !cmd.cs_n;
	wire is_mrs  = sel && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
	wire is_ref  = sel && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
	wire is_rd   = sel && cmd.ras_n && !cmd.cas_n && cmd.we_n;
	wire is_wr   = sel && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
	wire mrs0    = is_mrs && (cmd.ba == BA_MR0);
	wire mrs1    = is_mrs && (cmd.ba == BA_MR1);

	// Field decode
	wire [1:0]       bl_code = mode_register_zero[MR0_BL_LO +: 2];
	wire [3:0]       cl_code = {mode_register_zero[MR0_CL_A2], mode_register_zero[MR0_CL_LO +: 3]};
	wire [LAT_W-1:0] cl      = CL_BASE + LAT_W'(cl_code);
	wire [LAT_W-1:0] wr_rec  = WR_BASE + LAT_W'(mode_register_zero[MR0_WR_LO +: 3]);
	wire             ppd_fast = mode_register_zero[MR0_PPD];
	wire             test_mode = mode_register_zero[MR0_TEST];
	wire [1:0]       al_code = mode_register_one[MR1_AL_LO +: 2];
	wire             dll_off = mode_register_one[MR1_DLLOFF];
	wire [LAT_W-1:0] cwl     = LAT_W'(cfg[4:0]);
	wire [LAT_W-1:0] trp     = LAT_W'(cfg[9:5]);
	wire [1:0]       rtt_wr  = cfg[11:10];

	// Reserved additive code behaves as disabled
	wire [LAT_W-1:0] al = (al_code == AL_M1) ? cl - LAT_W'(1) :
		(al_code == AL_M2) ? cl - LAT_W'(2) : '0;
	wire [LAT_W-1:0] rl      = al + cl;
	wire [LAT_W-1:0] wl      = al + cwl;
	wire [LAT_W-1:0] wr_tail = (bl_code == BL_FIX4) ? TAIL_BC4 : TAIL_BL8;
	wire [LAT_W-1:0] wr_len  = wl + wr_tail;
	wire [LAT_W-1:0] ap_len  = wr_rec + trp;

	// Mode register storage; a DLL reset bit is consumed after one link clock
	wire dll_clr = (state == ST_DLLRST) && tick;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode_register_zero <= MR_RST;
			mode_register_one  <= MR_RST;
		end
		else
		begin
			if (mrs0)
				mode_register_zero <= cmd.addr;
			else if (dll_clr)
				mode_register_zero[MR0_DLLRST] <= 1'b0;
			if (mrs1)
				mode_register_one <= cmd.addr;
		end
	end

	// Power state: self-refresh, precharge power-down, DLL reset
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (mrs0 && cmd.addr[MR0_DLLRST])
					next_state = ST_DLLRST;
				else if (is_ref && !cmd.cke)
					next_state = ST_SREF;
				else if (tick && !cmd.cke)
					next_state = ST_PDN;
			ST_DLLRST:
				if (tick)
					next_state = ST_IDLE;
			ST_SREF:
				if (tick && cmd.cke)
					next_state = ST_IDLE;
			ST_PDN:
				if (tick && cmd.cke)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// DLL stops when disabled, in self-refresh, or frozen by slow-exit power-down
	assign dll_run = !dll_off && (state != ST_SREF) && !((state == ST_PDN) && !ppd_fast);
	assign dll_reset_pulse = dll_clr;

	// Read and write latency timers; auto-precharge waits for internal write
	ddm_lat_cnt u_rd (
		.clk   (clk),
		.rst   (rst),
		.tick  (tick),
		.start (is_rd),
		.len   (rl),
		.busy  (rd_busy),
		.done  (rd_data_start),
		.cnt   (rd_cnt)
	);

	ddm_lat_cnt u_wr (
		.clk   (clk),
		.rst   (rst),
		.tick  (tick),
		.start (is_wr),
		.len   (wr_len),
		.busy  (wr_busy),
		.done  (wr_done),
		.cnt   (wr_cnt)
	);

	ddm_lat_cnt u_ap (
		.clk   (clk),
		.rst   (rst),
		.tick  (tick),
		.start (wr_done && ap_pend),
		.len   (ap_len),
		.busy  (ap_busy),
		.done  (ap_start),
		.cnt   (ap_cnt)
	);

	always_ff @(posedge clk)
	begin
		if (rst)
			ap_pend <= 1'b0;
		else if (is_wr)
			ap_pend <= cmd.addr[CMD_AP];
		else if (wr_done)
			ap_pend <= 1'b0;
	end

	assign wr_internal   = wr_done;
	assign outputs_off   = mode_register_one[MR1_QOFF];
	assign drive_imp     = {mode_register_one[MR1_DIC1], mode_register_one[MR1_DIC0]};
	assign rtt_nom_code  = {mode_register_one[MR1_RTT2], mode_register_one[MR1_RTT1], mode_register_one[MR1_RTT0]};
	assign rtt_wr_on     = wr_busy && (rtt_wr != 2'h0);
	assign wr_dll_needed = (rtt_wr != 2'h0);
	assign read_latency  = rl;

	// Avalon slave: every access waits exactly one cycle
	wire        req      = read || write;
	wire        wr_cfg   = write && ack && (address == REG_CFG);
	wire [15:0] be_mask  = {{8{byteenable[1]}}, {8{byteenable[0]}}};
	wire [15:0] stat_w   = {8'h0, ap_busy, wr_busy, rd_busy, test_mode, state};
	wire [31:0] rd_mux   =
		(address == REG_MR0)  ? {18'h0, mode_register_zero} :
		(address == REG_MR1)  ? {18'h0, mode_register_one} :
		(address == REG_LAT)  ? {14'h0, wl, al, cl} :
		(address == REG_CFG)  ? {16'h0, cfg} :
		(address == REG_STAT) ? {16'h0, stat_w} : 32'h0;

	assign waitrequest = req && !ack;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ack      <= 1'b0;
			readdata <= 32'h0;
			cfg      <= CFG_RST;
		end
		else
		begin
			ack <= req && !ack;
			if (read && !ack)
				readdata <= rd_mux;
			if (wr_cfg)
				cfg <= (cfg & ~be_mask) | (writedata[15:0] & be_mask);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	cl_decode_a: assert property (is_rd |=> rd_cnt == ({1'b0, cl_code} + CL_BASE + al))
		else $error("read latency load mismatch");
	bc4_tail_a: assert property (is_wr && bl_code == BL_FIX4 |=> wr_cnt == wl + 6'h2)
		else $error("chop write not pulled in by two");
	otf_tail_a: assert property (is_wr && bl_code == BL_OTF |=> wr_cnt == wl + 6'h4)
		else $error("on-the-fly write pulled in");
	al_minus_a: assert property (al_code == AL_M2 |-> read_latency + 6'h2 == cl + cl)
		else $error("additive latency not CL minus two");
	dll_clear_a: assert property (state == ST_DLLRST && tick && !mrs0 |=> !mode_register_zero[MR0_DLLRST])
		else $error("DLL reset bit did not clear");
	mr1_hold_a: assert property (!mrs1 |=> $stable(mode_register_one))
		else $error("register one changed without set command");
	sref_dll_a: assert property (state == ST_SREF |-> !dll_run)
		else $error("DLL running in self-refresh");
	ppd_slow_a: assert property (state == ST_PDN && !ppd_fast |-> !dll_run)
		else $error("DLL not frozen in slow-exit power-down");
	ppd_fast_a: assert property (state == ST_PDN && ppd_fast && !dll_off |-> dll_run)
		else $error("DLL stopped in fast-exit power-down");
	ap_wait_a: assert property (wr_done && ap_pend |=> ap_cnt == wr_rec + trp)
		else $error("auto-precharge delay wrong");
	bus_wait_a: assert property (req && !ack |-> waitrequest ##1 (!waitrequest || !req))
		else $error("waitrequest not one cycle");

	rd_cov: cover property (rd_data_start);
	ap_cov: cover property (ap_start);
	sref_cov: cover property (state == ST_SREF ##1 state == ST_IDLE);
endmodule

// File: src/ddm_pkg.sv
// Shared constants and types for the mode-register block
package ddm_pkg;
	localparam int LAT_W = 6;
	localparam int ADR_W = 14;
	localparam int CMD_W = 22;

	// Bank codes that select a mode register
	localparam logic [2:0] BA_MR0 = 3'h0;
	localparam logic [2:0] BA_MR1 = 3'h1;

	// Field positions in mode_register_zero
	localparam int MR0_BL_LO = 0;
	localparam int MR0_CL_A2 = 2;
	localparam int MR0_CL_LO = 4;
	localparam int MR0_TEST  = 7;
	localparam int MR0_DLLRST = 8;
	localparam int MR0_WR_LO = 9;
	localparam int MR0_PPD   = 12;

	// Field positions in mode_register_one
	localparam int MR1_DLLOFF = 0;
	localparam int MR1_DIC0  = 1;
	localparam int MR1_RTT0  = 2;
	localparam int MR1_AL_LO = 3;
	localparam int MR1_DIC1  = 5;
	localparam int MR1_RTT1  = 6;
	localparam int MR1_WLVL  = 7;
	localparam int MR1_RTT2  = 9;
	localparam int MR1_QOFF  = 12;

	// Address bits sampled with read and write commands
	localparam int CMD_AP = 10;
	localparam int CMD_BC = 12;

	// Burst length and additive latency codes
	localparam logic [1:0] BL_FIX8 = 2'h0;
	localparam logic [1:0] BL_OTF  = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;
	localparam logic [1:0] AL_OFF  = 2'h0;
	localparam logic [1:0] AL_M1   = 2'h1;
	localparam logic [1:0] AL_M2   = 2'h2;

	// Latency bases and write tails, in link clocks
	localparam logic [LAT_W-1:0] CL_BASE  = 6'h4;
	localparam logic [LAT_W-1:0] WR_BASE  = 6'h4;
	localparam logic [LAT_W-1:0] TAIL_BL8 = 6'h4;
	localparam logic [LAT_W-1:0] TAIL_BC4 = 6'h2;

	// Register word addresses and reset values
	localparam logic [2:0] REG_MR0  = 3'h0;
	localparam logic [2:0] REG_MR1  = 3'h1;
	localparam logic [2:0] REG_LAT  = 3'h2;
	localparam logic [2:0] REG_CFG  = 3'h3;
	localparam logic [2:0] REG_STAT = 3'h4;
	localparam logic [ADR_W-1:0] MR_RST = 14'h0;
	localparam logic [15:0] CFG_RST = 16'h00a5;

	typedef struct packed {
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic              cke;
		logic [2:0]        ba;
		logic [ADR_W-1:0]  addr;
	} ddm_cmd_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_DLLRST = 4'b0010,
		ST_SREF   = 4'b0100,
		ST_PDN    = 4'b1000
	} ddm_state_t;
endpackage

// File: src/ddm_sync.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module ddm_sync
	import ddm_pkg::*;
#(
	parameter int W = CMD_W
)(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					meta[i] <= 1'b0;
					dout[i] <= 1'b0;
				end
				else
				begin
					meta[i] <= din[i];
					dout[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

// File: testbench/ddm_ctl_model.sv
// Controller model: free-running link clock and command pins
`timescale 1ns/1ps
module ddm_ctl_model
	import ddm_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Link pins
	output logic      ck,
	output ddm_cmd_t  cmd_pins
);
	logic [4:0] ph;

	initial
	begin
		ph = 5'h0;
		ck = 1'b0;
		cmd_pins = {5'h1f, 17'h0};
	end

	// Two link periods in 25 system cycles keep the 125 ns average
	always @(posedge clk)
	begin
		ph <= (ph == 5'h18) ? 5'h0 : ph + 5'h1;
		ck <= (ph < 5'h6) || (ph >= 5'hd && ph < 5'h13);
	end

	// Pins change on the fall, so they are long settled at the capturing rise
	task automatic issue(input logic [2:0] rcw, input logic cke, input logic [2:0] ba, input logic [13:0] a);
		@(negedge ck);
		cmd_pins <= {1'b0, rcw, cke, ba, a};
		@(negedge ck);
		// Deselected bank and address lines show the inverse, never a stale copy; cke keeps its level
		cmd_pins <= {4'hf, cke, ~ba, ~a};
	endtask
endmodule

// File: testbench/test_ddm_mode_regs.sv
// Self-checking bench for the mode-register block
`timescale 1ns/1ps
module test_ddm_mode_regs
	import ddm_pkg::*;
;
	localparam int DLL_LOCK = 4;
	logic             clk, rst, ck, read, write, waitrequest;
	logic [2:0]       address, rtt_nom_code;
	logic [3:0]       byteenable;
	logic [31:0]      writedata, readdata, rd;
	logic             rd_data_start, wr_internal, ap_start, dll_reset_pulse;
	logic             dll_run, outputs_off, rtt_wr_on, wr_dll_needed;
	logic [1:0]       drive_imp;
	logic [LAT_W-1:0] read_latency;
	ddm_cmd_t         cmd_pins;
	int               bad_count, n_checks, ticks, t_rd, t_wr, t_ap, n_rst, n_rtt, t0;

	initial
		clk = 1'b0;
	always #5 clk = ~clk;

	// Link waits count link clocks, so a stalled link clock is caught here
	initial
	begin
		repeat (50000) @(posedge clk);
		bad_count++;
		close_out();
	end

	ddm_ctl_model ctl (.clk(clk), .rst(rst), .ck(ck), .cmd_pins(cmd_pins));
	ddm_mode_regs DUT (.clk(clk), .rst(rst), .ck(ck), .cmd_pins(cmd_pins), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .rd_data_start(rd_data_start), .wr_internal(wr_internal),
		.ap_start(ap_start), .dll_reset_pulse(dll_reset_pulse), .dll_run(dll_run), .outputs_off(outputs_off),
		.drive_imp(drive_imp), .rtt_nom_code(rtt_nom_code), .rtt_wr_on(rtt_wr_on),
		.wr_dll_needed(wr_dll_needed), .read_latency(read_latency));

	always @(posedge ck)
		ticks++;
	always @(posedge clk)
	begin
		if (rd_data_start === 1'b1) t_rd = ticks;
		if (wr_internal === 1'b1) t_wr = ticks;
		if (ap_start === 1'b1) t_ap = ticks;
		if (dll_reset_pulse === 1'b1) n_rst++;
		if (rtt_wr_on === 1'b1) n_rtt++;
	end

	task automatic close_out;
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		byteenable <= be;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 20);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0)
		begin
			bad_count++;
			close_out();
		end
	endtask

	task automatic rdreg(input logic [2:0] a, input logic [31:0] exp, input string msg);
		av(1'b0, a, 32'h0, 4'h0);
		check(rd, exp, msg);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge ck);
	endtask

	task automatic t_reset;
		rdreg(REG_MR0, 32'h0, "mr0 reset");
		rdreg(REG_CFG, 32'h00a5, "cfg reset");
		rdreg(REG_STAT, 32'h1, "stat idle");
		rdreg(3'h5, 32'h0, "unmapped read");
		av(1'b1, REG_MR0, 32'h1fff, 4'hf);
		rdreg(REG_MR0, 32'h0, "mr0 read-only");
		check(dll_run, 1'b1, "dll on at reset");
		$display("Test reset done");
	endtask

	task automatic t_mr1;
		ctl.issue(3'b000, 1'b1, 3'h2, 14'h106e);
		check(outputs_off, 1'b0, "other bank ignored");
		ctl.issue(3'b000, 1'b1, BA_MR1, 14'h106e);
		check(drive_imp, 2'h3, "drive impedance");
		check(rtt_nom_code, 3'h3, "nominal termination");
		check(outputs_off, 1'b1, "outputs off");
		check(read_latency, 6'h7, "al minus one");
		rdreg(REG_MR1, 32'h106e, "mr1 stored");
		ctl.issue(3'b000, 1'b1, BA_MR1, 14'h0001);
		check(dll_run, 1'b0, "dll off mode");
		check(outputs_off, 1'b0, "outputs back on");
		ctl.issue(3'b000, 1'b1, BA_MR1, 14'h0008);
		check(dll_run, 1'b1, "dll back on");
		$display("Test mr1 done");
	endtask

	task automatic t_lat;
		ctl.issue(3'b000, 1'b1, BA_MR0, 14'h0222);
		check(read_latency, 6'hb, "read latency");
		n_rst = 0;
		ctl.issue(3'b000, 1'b1, BA_MR0, 14'h0322);
		wt(2);
		check(n_rst, 1, "one dll reset pulse");
		wt(1);
		rdreg(REG_MR0, 32'h0222, "dll reset bit cleared");
		wt(DLL_LOCK);
		ctl.issue(3'b101, 1'b1, 3'h0, 14'h0);
		t0 = ticks;
		wt(12);
		check(t_rd - t0, 11, "read data start");
		ctl.issue(3'b100, 1'b1, 3'h0, 14'h0400);
		t0 = ticks;
		wt(24);
		check(t_wr - t0, 12, "chop write start");
		check(t_ap - t_wr, 10, "auto-precharge");
		ctl.issue(3'b000, 1'b1, BA_MR0, 14'h0221);
		ctl.issue(3'b100, 1'b1, 3'h0, 14'h0000);
		t0 = ticks;
		wt(15);
		check(t_wr - t0, 14, "on-the-fly write start");
		ctl.issue(3'b000, 1'b1, BA_MR1, 14'h0010);
		check(read_latency, 6'ha, "al minus two");
		ctl.issue(3'b000, 1'b1, BA_MR1, 14'h0018);
		check(read_latency, 6'h6, "reserved al code");
		$display("Test latency done");
	endtask

	task automatic t_pd;
		ctl.issue(3'b111, 1'b0, 3'h0, 14'h0);
		check(dll_run, 1'b0, "slow-exit power-down");
		rdreg(REG_STAT, 32'h8, "stat power-down");
		ctl.issue(3'b111, 1'b1, 3'h0, 14'h0);
		check(dll_run, 1'b1, "power-down exit");
		ctl.issue(3'b000, 1'b1, BA_MR0, 14'h1221);
		ctl.issue(3'b111, 1'b0, 3'h0, 14'h0);
		check(dll_run, 1'b1, "fast-exit power-down");
		ctl.issue(3'b111, 1'b1, 3'h0, 14'h0);
		ctl.issue(3'b001, 1'b0, 3'h0, 14'h0);
		check(dll_run, 1'b0, "self-refresh dll");
		rdreg(REG_STAT, 32'h4, "stat self-refresh");
		ctl.issue(3'b111, 1'b1, 3'h0, 14'h0);
		check(dll_run, 1'b1, "self-refresh exit");
		$display("Test power-down done");
	endtask

	task automatic t_term;
		av(1'b1, REG_CFG, 32'h04ff, 4'h2);
		rdreg(REG_CFG, 32'h04a5, "cfg lane write");
		check(wr_dll_needed, 1'b1, "write needs dll");
		n_rtt = 0;
		ctl.issue(3'b100, 1'b1, 3'h0, 14'h0);
		wt(16);
		check(n_rtt > 0, 1, "write termination");
		av(1'b1, REG_CFG, 32'h00a5, 4'h3);
		rdreg(REG_CFG, 32'h00a5, "cfg restored");
		check(wr_dll_needed, 1'b0, "write without dll");
		n_rtt = 0;
		ctl.issue(3'b100, 1'b1, 3'h0, 14'h0);
		wt(16);
		check(n_rtt, 0, "no write termination");
		$display("Test termination done");
	endtask

	initial
	begin
		rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 3'h0;
		writedata = 32'h0;
		byteenable = 4'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_mr1();
		t_lat();
		t_pd();
		t_term();
		close_out();
	end
endmodule
